// [design/arr_pkg.sv]
// types shared by the result readout bank
package arr_pkg;

	typedef enum logic [1:0] {
		ARR_CH_BUS_CUR = 2'h0,
		ARR_CH_BUS_VOLT = 2'h1,
		ARR_CH_ADAPT = 2'h2,
		ARR_CH_OUT = 2'h3
	} arr_chan_t;

	// one finished conversion from the converter
	typedef struct packed {
		logic valid;
		arr_chan_t chan;
		logic [15:0] data;
	} arr_conv_t;

	// one access on the internal register port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} arr_req_t;

	// decoded offset
	typedef struct packed {
		logic hit;
		arr_chan_t chan;
		logic high;
	} arr_dec_t;

	// state of the readout front end
	typedef struct packed {
		logic pend;
		logic [7:0] addr;
		logic rvalid;
		logic hit;
		logic [7:0] rdata;
		logic wr_refused;
	} arr_state_t;

endpackage

// [design/arr_readout.sv]
// measurement result readout bank on the internal register port
//
// Overview of operation
// - 0x17 returns bus current bits 7..0
// - 0x18 returns bus voltage sign, bits 14..8
// - 0x19 returns bus voltage bits 7..0
// - 0x1A returns adapter voltage sign, bits 14..8
// - 0x1B returns adapter voltage bits 7..0
// - 0x1C returns output voltage sign, bits 14..8
// - 0x1D returns output voltage bits 7..0
// - results two's complement, sign one means negative
// - soft reset clears results, watchdog does not
`timescale 1ns/10ps
`default_nettype none
`include "arr_regs.svh"

module arr_readout
	import arr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_REG_RST,
	input wire logic I_WDOG_EXPIRE,
	input wire arr_conv_t I_CONV,
	input wire arr_req_t I_REQ,
	output logic O_REG_RVALID,
	output logic O_REG_HIT,
	output logic [7:0] O_REG_RDATA,
	output logic O_WR_REFUSED
);

	arr_state_t state_reg;
	arr_state_t state_next;
	arr_dec_t rd_dec;
	arr_dec_t pend_dec;
	logic [15:0] store_rdata;

	// offset decode; 0x16 (bus current high byte) lives elsewhere and misses here
	function automatic arr_dec_t arr_decode(input logic [7:0] addr);
		arr_dec_t d;
		d = '{hit: 1'b1, chan: ARR_CH_BUS_CUR, high: 1'b0};
		unique case (addr)
			`ARR_OFF_BUS_CUR_LOW: d.chan = ARR_CH_BUS_CUR;
			`ARR_OFF_BUS_VOLT_HIGH: d = '{1'b1, ARR_CH_BUS_VOLT, 1'b1};
			`ARR_OFF_BUS_VOLT_LOW: d.chan = ARR_CH_BUS_VOLT;
			`ARR_OFF_ADAPT_HIGH: d = '{1'b1, ARR_CH_ADAPT, 1'b1};
			`ARR_OFF_ADAPT_LOW: d.chan = ARR_CH_ADAPT;
			`ARR_OFF_OUT_HIGH: d = '{1'b1, ARR_CH_OUT, 1'b1};
			`ARR_OFF_OUT_LOW: d.chan = ARR_CH_OUT;
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction

	assign rd_dec = arr_decode(I_REQ.addr);
	assign pend_dec = arr_decode(state_reg.addr);

	// the converter is the only writer; the watchdog input is deliberately unused
	arr_result_store #(
		.WIDTH(`ARR_RESULT_WIDTH),
		.DEPTH(`ARR_CHAN_COUNT),
		.AW(2)
	) u_store (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_clear(I_REG_RST),
		.i_we(I_CONV.valid),
		.i_waddr(I_CONV.chan),
		.i_wdata(I_CONV.data),
		.i_raddr(rd_dec.chan),
		.o_rdata(store_rdata)
	);

	// read pipeline: address taken, word fetched, byte picked one cycle later
	always_comb begin
		state_next = state_reg;
		state_next.pend = I_REQ.rd;
		if (I_REQ.rd) begin
			state_next.addr = I_REQ.addr;
		end
		state_next.rvalid = state_reg.pend;
		// writes never reach the store; the refusal is only reported
		state_next.wr_refused = I_REQ.wr && rd_dec.hit;
		if (state_reg.pend) begin
			state_next.hit = pend_dec.hit;
			if (!pend_dec.hit) begin
				state_next.rdata = `ARR_BYTE_RESET;
			end else if (pend_dec.high) begin
				// sign is bit 15 of the two's complement word, passed untouched
				state_next.rdata = {store_rdata[`ARR_SIGN_BIT],
					store_rdata[`ARR_HIGH_MSB:`ARR_HIGH_LSB]};
			end else begin
				state_next.rdata = store_rdata[`ARR_LOW_MSB:`ARR_LOW_LSB];
			end
		end
	end

	// output byte holds until the next read completes
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign O_REG_RVALID = state_reg.rvalid;
	assign O_REG_HIT = state_reg.hit;
	assign O_REG_RDATA = state_reg.rdata;
	assign O_WR_REFUSED = state_reg.wr_refused;

	// conversion on a channel, read of one offset next cycle, byte shows two cycles later
	property p_wr_rd(arr_chan_t ch, logic [7:0] off, logic high);
		@(posedge I_CLK) disable iff (I_SRST)
		(I_CONV.valid && I_CONV.chan == ch && !I_REG_RST) ##1
		(I_REQ.rd && I_REQ.addr == off && !I_REG_RST) ##1 !I_REG_RST
		|-> ##1 (O_REG_RVALID && O_REG_HIT && O_REG_RDATA ==
			(high ? $past(I_CONV.data[15:8], 3) : $past(I_CONV.data[7:0], 3)));
	endproperty

	a_bus_cur_low: assert property (p_wr_rd(ARR_CH_BUS_CUR, `ARR_OFF_BUS_CUR_LOW, 1'b0))
		else $error("bus current low byte wrong");
	a_bus_volt_high: assert property (p_wr_rd(ARR_CH_BUS_VOLT, `ARR_OFF_BUS_VOLT_HIGH, 1'b1))
		else $error("bus voltage high byte wrong");
	a_bus_volt_low: assert property (p_wr_rd(ARR_CH_BUS_VOLT, `ARR_OFF_BUS_VOLT_LOW, 1'b0))
		else $error("bus voltage low byte wrong");
	a_adapt_high: assert property (p_wr_rd(ARR_CH_ADAPT, `ARR_OFF_ADAPT_HIGH, 1'b1))
		else $error("adapter voltage high byte wrong");
	a_adapt_low: assert property (p_wr_rd(ARR_CH_ADAPT, `ARR_OFF_ADAPT_LOW, 1'b0))
		else $error("adapter voltage low byte wrong");
	a_out_high: assert property (p_wr_rd(ARR_CH_OUT, `ARR_OFF_OUT_HIGH, 1'b1))
		else $error("output voltage high byte wrong");
	a_out_low: assert property (p_wr_rd(ARR_CH_OUT, `ARR_OFF_OUT_LOW, 1'b0))
		else $error("output voltage low byte wrong");

	// a negative output voltage must read with the sign flag set
	a_sign_negative: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_CONV.valid && I_CONV.chan == ARR_CH_OUT && I_CONV.data[15] && !I_REG_RST) ##1
		(I_REQ.rd && I_REQ.addr == `ARR_OFF_OUT_HIGH && !I_REG_RST) ##1 !I_REG_RST
		|-> ##1 (O_REG_RVALID && O_REG_RDATA[7]))
		else $error("negative result read without sign flag");

	// offset range of the bank, worked out apart from the decode function on purpose
	logic req_in_bank;
	assign req_in_bank = I_REQ.addr >= `ARR_OFF_BUS_CUR_LOW && I_REQ.addr <= `ARR_OFF_OUT_LOW;

	// a read right after the soft reset returns zero for every mapped offset
	a_soft_clear: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REG_RST ##1 (I_REQ.rd && req_in_bank)
		|-> ##2 (O_REG_RVALID && O_REG_RDATA == `ARR_BYTE_RESET))
		else $error("result not cleared by soft reset");

	// a watchdog expiry between conversion and read leaves the byte intact
	a_wdog_keeps: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_CONV.valid && I_CONV.chan == ARR_CH_ADAPT && !I_REG_RST) ##1
		(I_WDOG_EXPIRE && !I_CONV.valid && !I_REG_RST) ##1
		(I_REQ.rd && I_REQ.addr == `ARR_OFF_ADAPT_LOW && !I_REG_RST) ##1 !I_REG_RST
		|-> ##1 (O_REG_RDATA == $past(I_CONV.data[7:0], 4)))
		else $error("watchdog disturbed a result");

	// a software write between conversion and read changes nothing; refusal seen after its edge
	a_write_ignored: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_CONV.valid && I_CONV.chan == ARR_CH_BUS_VOLT && !I_REG_RST) ##1
		(I_REQ.wr && I_REQ.addr == `ARR_OFF_BUS_VOLT_LOW && !I_CONV.valid && !I_REG_RST) ##1
		(I_REQ.rd && I_REQ.addr == `ARR_OFF_BUS_VOLT_LOW && !I_REG_RST) ##1 !I_REG_RST
		|-> ##1 (O_REG_RDATA == $past(I_CONV.data[7:0], 4) && $past(O_WR_REFUSED, 2)))
		else $error("software write altered a result");

	// every read is answered by a valid pulse two samples after it is taken
	a_read_answered: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REQ.rd |-> ##2 O_REG_RVALID)
		else $error("read not answered in time");

	// a valid pulse only ever follows a read
	a_valid_from_read: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_REG_RVALID |-> $past(I_REQ.rd, 2))
		else $error("read data valid without a read");

	// valid lasts one cycle unless reads come back to back
	a_valid_one_cycle: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_REG_RVALID && !$past(I_REQ.rd) |=> !O_REG_RVALID)
		else $error("read data valid held too long");

	// an offset outside the bank answers with a miss and a zero byte
	a_miss_zero: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REQ.rd && !req_in_bank
		|-> ##2 (O_REG_RVALID && !O_REG_HIT && O_REG_RDATA == `ARR_BYTE_RESET))
		else $error("unmapped offset not answered as a miss");

	// a mapped offset answers with a hit
	a_hit_mapped: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REQ.rd && req_in_bank |-> ##2 (O_REG_RVALID && O_REG_HIT))
		else $error("mapped offset answered as a miss");

	// a write to a mapped offset is reported refused on the next sample
	a_refuse_mapped: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REQ.wr && req_in_bank |=> O_WR_REFUSED)
		else $error("write to a result not reported refused");

	// a write outside the bank is not ours to refuse
	a_refuse_unmapped: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_REQ.wr && !req_in_bank |=> !O_WR_REFUSED)
		else $error("refusal reported for an unmapped write");

	// a refusal is only reported right after a write
	a_refuse_cause: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_WR_REFUSED |-> $past(I_REQ.wr))
		else $error("refusal reported without a write");

	// the read byte holds between completed reads; writes never disturb it
	a_rdata_hold: assert property (@(posedge I_CLK) disable iff (I_SRST)
		!O_REG_RVALID && !$past(I_SRST) |-> $stable(O_REG_RDATA))
		else $error("read byte changed without a read");

	c_read_high: cover property (@(posedge I_CLK) disable iff (I_SRST)
		O_REG_RVALID && O_REG_HIT && O_REG_RDATA[7]);
	c_read_miss: cover property (@(posedge I_CLK) disable iff (I_SRST)
		O_REG_RVALID && !O_REG_HIT);
	c_clear_then_read: cover property (@(posedge I_CLK) disable iff (I_SRST)
		I_REG_RST ##1 I_REQ.rd ##2 O_REG_RVALID);
	c_refused: cover property (@(posedge I_CLK) disable iff (I_SRST) O_WR_REFUSED);

endmodule

`default_nettype wire

// [design/arr_regs.svh]
// offsets, field positions, reset values and widths of the result readout bank
`ifndef ARR_REGS_SVH
`define ARR_REGS_SVH

`define ARR_OFF_BUS_CUR_LOW 8'h17
`define ARR_OFF_BUS_VOLT_HIGH 8'h18
`define ARR_OFF_BUS_VOLT_LOW 8'h19
`define ARR_OFF_ADAPT_HIGH 8'h1A
`define ARR_OFF_ADAPT_LOW 8'h1B
`define ARR_OFF_OUT_HIGH 8'h1C
`define ARR_OFF_OUT_LOW 8'h1D

`define ARR_SIGN_BIT 15
`define ARR_HIGH_MSB 14
`define ARR_HIGH_LSB 8
`define ARR_LOW_MSB 7
`define ARR_LOW_LSB 0

`define ARR_RESULT_RESET 16'h0000
`define ARR_BYTE_RESET 8'h00
`define ARR_RESULT_WIDTH 16
`define ARR_CHAN_COUNT 4
`define ARR_READ_LATENCY 2

`endif

// [design/arr_result_store.sv]
// result word store: one word per channel, clearable, registered read data
`timescale 1ns/10ps
`default_nettype none

module arr_result_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_clear,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0] rdata;
	} arr_store_state_t;

	arr_store_state_t state_reg;
	arr_store_state_t state_next;

	// clear beats a conversion in the same cycle; a read in that cycle already sees zero
	always_comb begin
		state_next = state_reg;
		state_next.rdata = i_clear ? '0 : state_reg.words[i_raddr];
		if (i_clear) begin
			state_next.words = '0;
		end else if (i_we) begin
			state_next.words[i_waddr] = i_wdata;
		end
	end

	// words are held at zero after power-on so reads are never undefined
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rdata = state_reg.rdata;

endmodule

`default_nettype wire

// [test/tb.sv]
// self-checking bench for the result readout bank
`timescale 1ns/10ps
`default_nettype none
`include "arr_regs.svh"

module tb
	import arr_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_reg_rst = 1'b0;
	logic i_wdog = 1'b0;
	arr_conv_t conv = '0;
	arr_req_t req = '0;
	logic rvalid;
	logic hit;
	logic wr_refused;
	logic [7:0] rdata;
	logic [15:0] exp_w [4];
	int bad_count = 0;
	int cmp_count = 0;

	// device under test, every input driven by the bench
	arr_readout dut (
		.I_CLK(i_clk),
		.I_SRST(i_srst),
		.I_REG_RST(i_reg_rst),
		.I_WDOG_EXPIRE(i_wdog),
		.I_CONV(conv),
		.I_REQ(req),
		.O_REG_RVALID(rvalid),
		.O_REG_HIT(hit),
		.O_REG_RDATA(rdata),
		.O_WR_REFUSED(wr_refused)
	);

	// 25 MHz clock
	initial begin
		forever #20 i_clk = ~i_clk;
	end

	// compare one byte, case equality so an unknown never matches
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one read; the valid pulse shows right after the edge that follows the taking edge
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input logic exp_hit);
		int n;
		@(posedge i_clk);
		req.rd <= 1'b1;
		req.addr <= addr;
		@(posedge i_clk);
		req.rd <= 1'b0;
		#1;
		for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		if (rvalid !== 1'b1) begin
			bad_count++;
			close_out();
		end
		check(8'(n), 8'h01);
		check(rdata, exp);
		check({7'h00, hit}, {7'h00, exp_hit});
	endtask

	// one write; a mapped offset answers with a refusal pulse right after the taking edge
	task automatic wr_chk(input logic [7:0] addr, input logic exp_ref);
		@(posedge i_clk);
		req.wr <= 1'b1;
		req.addr <= addr;
		req.wdata <= 8'hFF;
		@(posedge i_clk);
		req.wr <= 1'b0;
		#1;
		check({7'h00, wr_refused}, {7'h00, exp_ref});
	endtask

	// one conversion result into a channel, remembered as the expectation
	task automatic load(input arr_chan_t ch, input logic [15:0] d);
		@(posedge i_clk);
		conv <= '{valid: 1'b1, chan: ch, data: d};
		exp_w[ch] = d;
		@(posedge i_clk);
		conv.valid <= 1'b0;
	endtask

	// conversion with a read right behind it, or with one write or watchdog cycle between
	task automatic load_rd(input arr_chan_t ch, input logic [15:0] d, input logic [7:0] off,
		input logic [7:0] exp, input logic gap, input logic gap_wr);
		@(posedge i_clk);
		conv <= '{valid: 1'b1, chan: ch, data: d};
		exp_w[ch] = d;
		if (gap) begin
			@(posedge i_clk);
			conv.valid <= 1'b0;
			req.wr <= gap_wr;
			req.addr <= off;
			req.wdata <= 8'hFF;
			i_wdog <= !gap_wr;
		end
		fork
			rd_chk(off, exp, 1'b1);
			begin
				@(posedge i_clk);
				conv.valid <= 1'b0;
				req.wr <= 1'b0;
				i_wdog <= 1'b0;
				#1;
				if (gap) begin
					check({7'h00, wr_refused}, {7'h00, gap_wr});
				end
			end
		join
	endtask

	// read every mapped offset plus both neighbours outside the bank
	task automatic sweep(input string name);
		logic [7:0] off;
		logic [15:0] w;
		for (int i = 0; i < 7; i++) begin
			off = `ARR_OFF_BUS_CUR_LOW + 8'(i);
			w = exp_w[(i + 1) / 2];
			rd_chk(off, (i % 2 == 1) ? w[15:8] : w[7:0], 1'b1);
		end
		rd_chk(8'h16, 8'h00, 1'b0);
		rd_chk(8'h1E, 8'h00, 1'b0);
		$display("test %s done", name);
	endtask

	// main sequence: reset values, mapping, refused writes, watchdog, soft reset
	initial begin
		exp_w = '{default: 16'h0000};
		repeat (3) @(posedge i_clk);
		i_srst <= 1'b0;
		sweep("reset values");
		// signs chosen so both polarities show in the high bytes
		load(ARR_CH_BUS_CUR, 16'h8A5C);
		load(ARR_CH_BUS_VOLT, 16'hC3A5);
		load(ARR_CH_ADAPT, 16'h7F01);
		load(ARR_CH_OUT, 16'h8000);
		sweep("byte mapping");
		for (int i = 0; i < 7; i++) begin
			wr_chk(8'h17 + 8'(i), 1'b1);
		end
		wr_chk(8'h16, 1'b0);
		// watchdog held for a few cycles must leave results alone
		@(posedge i_clk);
		i_wdog <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_wdog <= 1'b0;
		sweep("writes and watchdog");
		// reads right behind conversions or one write or watchdog cycle later, so the byte-path checks see real traffic
		load_rd(ARR_CH_BUS_CUR, 16'h1234, `ARR_OFF_BUS_CUR_LOW, 8'h34, 1'b0, 1'b0);
		load_rd(ARR_CH_BUS_VOLT, 16'hA55A, `ARR_OFF_BUS_VOLT_HIGH, 8'hA5, 1'b0, 1'b0);
		load_rd(ARR_CH_BUS_VOLT, 16'h5AA5, `ARR_OFF_BUS_VOLT_LOW, 8'hA5, 1'b0, 1'b0);
		load_rd(ARR_CH_BUS_VOLT, 16'h3C96, `ARR_OFF_BUS_VOLT_LOW, 8'h96, 1'b1, 1'b1);
		load_rd(ARR_CH_ADAPT, 16'h0F96, `ARR_OFF_ADAPT_HIGH, 8'h0F, 1'b0, 1'b0);
		load_rd(ARR_CH_ADAPT, 16'h0F69, `ARR_OFF_ADAPT_LOW, 8'h69, 1'b0, 1'b0);
		load_rd(ARR_CH_ADAPT, 16'hF0E1, `ARR_OFF_ADAPT_LOW, 8'hE1, 1'b1, 1'b0);
		load_rd(ARR_CH_OUT, 16'hFE80, `ARR_OFF_OUT_HIGH, 8'hFE, 1'b0, 1'b0);
		load_rd(ARR_CH_OUT, 16'h00C3, `ARR_OFF_OUT_LOW, 8'hC3, 1'b0, 1'b0);
		sweep("read behind conversion");
		// soft reset wins over a conversion in the same cycle; the read right behind sees zero
		exp_w = '{default: 16'h0000};
		@(posedge i_clk);
		i_reg_rst <= 1'b1;
		conv <= '{valid: 1'b1, chan: ARR_CH_OUT, data: 16'h1234};
		fork
			rd_chk(`ARR_OFF_OUT_LOW, 8'h00, 1'b1);
			begin
				@(posedge i_clk);
				i_reg_rst <= 1'b0;
				conv.valid <= 1'b0;
			end
		join
		sweep("soft reset");
		close_out();
	end
endmodule

`default_nettype wire
